/* ppc_pkg.sv */
// constants, register map and packed types for the eight-pin port block
// assumes one 200 MHz clock and an AHB-Lite register bus
//
// Functional notes
// - analog hi-z default: driver off, input buffer off, no digital input value
// - digital hi-z: driver off, input buffer on, pin is an input
// - resistive pull modes: one state through resistor, other strong, in and out usable
// - special pins in regulated mode refuse resistive drive modes
// - open-drain modes: hi-z on one state, strong on the other, in and out
// - strong mode drives both states; normally not used as input
// - combined resistive: high pulls up, low pulls down, always via resistor
// - every pin register reachable port-wide, one bit per pin
// - per-pin register gathers eight bits; both forms act on same controls
// - bidirectional: output-enable signal switches between digital hi-z and chosen mode
// - auxiliary bus carries up to 16 output enables, routable to any pins
// - slew select applies to strong and open-drain modes only
// - slew choice held per pin in slew register
// - all eight pins feed one port interrupt unit with own request line
// - per-pin interrupt type: none, rising, falling, both
// - matching edge sets pin status bit and raises interrupt request
// - edge detection runs regardless of sleep state
// - no level-sensitive detection offered
// - port-level threshold select: cmos or lvttl
// - per-pin input buffer disable in any drive mode
// - special pins select supply-level or regulated high output per pin
// - special pins paired, shared reference, four threshold choices (two for the first pair, its low bit tied low)
// - three-bit drive mode encoding 0..7 as listed
// - reads return pin states; writes go to separate output latch
// - during reset pins analog hi-z; at release copy stored reset config

package ppc_pkg;

  localparam int unsigned NPINS = 8;
  localparam int unsigned NOE   = 16;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_LATCH  = 8'h00;
  localparam logic [7:0] OFS_STATE  = 8'h04;
  localparam logic [7:0] OFS_DM0    = 8'h08;
  localparam logic [7:0] OFS_DM1    = 8'h0c;
  localparam logic [7:0] OFS_DM2    = 8'h10;
  localparam logic [7:0] OFS_SLEW   = 8'h14;
  localparam logic [7:0] OFS_BIDIR  = 8'h18;
  localparam logic [7:0] OFS_INDIS  = 8'h1c;
  localparam logic [7:0] OFS_REGOUT = 8'h20;
  localparam logic [7:0] OFS_ITYP0  = 8'h24;
  localparam logic [7:0] OFS_ITYP1  = 8'h28;
  localparam logic [7:0] OFS_ISTAT  = 8'h2c;
  localparam logic [7:0] OFS_PCFG   = 8'h30;
  localparam logic [7:0] OFS_OESEL  = 8'h34;
  localparam logic [7:0] OFS_PIN0   = 8'h40;
  localparam logic [7:0] OFS_PINEND = 8'h5c;

  // per-pin register layout
  localparam int unsigned PB_LATCH = 0;
  localparam int unsigned PB_DM    = 1;
  localparam int unsigned PB_SLEW  = 4;
  localparam int unsigned PB_BIDIR = 5;
  localparam int unsigned PB_INDIS = 6;
  localparam int unsigned PB_STATE = 7;

  // port config layout
  localparam int unsigned PC_LVTTL = 0;
  localparam int unsigned PC_THR   = 1;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    DM_HIZ_ANALOG = 3'h0,
    DM_HIZ_DIGITAL = 3'h1,
    DM_RES_UP     = 3'h2,
    DM_RES_DOWN   = 3'h3,
    DM_OD_LOW     = 3'h4,
    DM_OD_HIGH    = 3'h5,
    DM_STRONG     = 3'h6,
    DM_RES_BOTH   = 3'h7
  } ppc_dm_type;

  typedef enum logic [1:0] {
    IT_NONE    = 2'h0,
    IT_RISING  = 2'h1,
    IT_FALLING = 2'h2,
    IT_BOTH    = 2'h3
  } ppc_itype_type;

  // pad control per pin
  typedef struct packed {
    logic drv_high;  // strong high
    logic drv_low;   // strong low
    logic res_up;    // resistive pull-up
    logic res_down;  // resistive pull-down
    logic in_en;     // digital input buffer
    logic slew_slow;
    logic reg_high;  // regulated high level
  } ppc_pad_type;

  typedef struct packed {
    logic [7:0] dm0;
    logic [7:0] dm1;
    logic [7:0] dm2;
  } ppc_rstcfg_type;

endpackage : ppc_pkg

/* ppc_port.sv */
// eight-pin port: drive modes, bidirectional switching, pin interrupts
// assumes an AHB-Lite master on mclk_i and asynchronous pin inputs
`timescale 1ns/1ps

module ppc_port #(
  parameter int unsigned NSPECIAL = 8
) (
  input  wire logic                               mclk_i,
  input  wire logic                               rst_n_i,
  input  wire logic                               hsel_i,
  input  wire logic [31:0]                        haddr_i,
  input  wire logic [1:0]                         htrans_i,
  input  wire logic                               hwrite_i,
  input  wire logic [2:0]                         hsize_i,
  input  wire logic [31:0]                        hwdata_i,
  input  wire logic                               hready_i,
  output logic      [31:0]                        hrdata_o,
  output logic                                    hreadyout_o,
  output logic                                    hresp_o,
  input  wire logic [7:0]                         pin_in_i,
  input  wire logic [ppc_pkg::NOE-1:0]            aux_oe_i,
  input  wire ppc_pkg::ppc_rstcfg_type            nv_rstcfg_i,
  output ppc_pkg::ppc_pad_type [7:0]              pad_o,
  output logic                                    lvttl_o,
  output logic      [7:0]                         sp_thr_o,
  output logic      [7:0]                         din_o,
  output logic                                    irq_o
);

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] latch_q, dm0_q, dm1_q, dm2_q, slew_q, bidir_q, indis_q, regout_q;
  logic [7:0] ityp0_q, ityp1_q, istat_q, pcfg_q;
  logic [31:0] oesel_q;
  logic        boot_q;

  // ****************************************
  // pin synchroniser and edge detection
  // ****************************************
  logic [7:0] s1_q, s2_q, s3_q;
  always_ff @(posedge mclk_i) begin
    s1_q <= pin_in_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // ****************************************
  // pad decode
  // ****************************************
  function automatic ppc_pkg::ppc_pad_type pad_f(input logic [2:0] dm, input logic d,
                                                 input logic oe, input logic bidir,
                                                 input logic dis, input logic slw,
                                                 input logic rg, input logic sp);
    ppc_pkg::ppc_pad_type p;
    logic [2:0] m;
    p = '0;
    m = (bidir && !oe) ? 3'h1 : dm;
    // regulated special pins map pull-up and pull-down to open-drain forms and combined resistive to digital hi-z, never resistive
    if (sp && rg && (m == 3'h2)) m = 3'h4;
    if (sp && rg && (m == 3'h3)) m = 3'h5;
    if (sp && rg && (m == 3'h7)) m = 3'h1;
    case (m)
      3'h0: p.in_en = 1'b0;
      3'h1: p.in_en = 1'b1;
      3'h2: begin
        p.res_up  = d;
        p.drv_low = !d;
        p.in_en   = 1'b1;
      end
      3'h3: begin
        p.drv_high = d;
        p.res_down = !d;
        p.in_en    = 1'b1;
      end
      3'h4: begin
        p.drv_low = !d;
        p.in_en   = 1'b1;
      end
      3'h5: begin
        p.drv_high = d;
        p.in_en    = 1'b1;
      end
      3'h6: begin
        p.drv_high = d;
        p.drv_low  = !d;
        p.in_en    = 1'b1;
      end
      default: begin
        p.res_up   = d;
        p.res_down = !d;
        p.in_en    = 1'b1;
      end
    endcase
    if (dis) p.in_en = 1'b0;
    p.slew_slow = slw && (m >= 3'h4) && (m <= 3'h6);
    p.reg_high  = sp && rg;
    return p;
  endfunction : pad_f

  logic [7:0]               oe_pin;
  ppc_pkg::ppc_pad_type [7:0] pad_d;
  logic [7:0]               din_d;
  logic [7:0]               edge_hit;
  logic [7:0]               ev_rise, ev_fall;

  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign oe_pin[i] = aux_oe_i[oesel_q[4*i +: 4]];
    assign pad_d[i]  = pad_f({dm2_q[i], dm1_q[i], dm0_q[i]}, latch_q[i], oe_pin[i], bidir_q[i],
                             indis_q[i], slew_q[i], regout_q[i], (i < NSPECIAL));
    assign din_d[i]  = s2_q[i] & pad_d[i].in_en;
    assign ev_rise[i] = !s3_q[i] && s2_q[i];
    assign ev_fall[i] = s3_q[i] && !s2_q[i];
    // edge only, no level option; runs on every clock irrespective of sleep
    assign edge_hit[i] = (ityp0_q[i] && ev_rise[i]) || (ityp1_q[i] && ev_fall[i]);
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic       aph_q, wr_q;
  logic [7:0] ad_q;
  wire        take    = hsel_i && hready_i && htrans_i[1];
  wire        pin_acc = (ad_q >= ppc_pkg::OFS_PIN0) && (ad_q <= ppc_pkg::OFS_PINEND);
  wire [2:0]  pidx    = 3'((ad_q - ppc_pkg::OFS_PIN0) >> 2);
  wire        wr      = aph_q && wr_q;
  // read data is decoded in the address phase so it stands in the data phase
  wire [7:0]  ra      = haddr_i[7:0];
  wire        rpin    = (ra >= ppc_pkg::OFS_PIN0) && (ra <= ppc_pkg::OFS_PINEND);
  wire [2:0]  rpidx   = 3'((ra - ppc_pkg::OFS_PIN0) >> 2);
  // clear on the same edge that captures the status, so no edge slips between
  wire        rd_stat = take && !hwrite_i && (ra == ppc_pkg::OFS_ISTAT);
  wire [7:0]  wb      = hwdata_i[7:0];

  function automatic logic [7:0] upd_f(input logic [7:0] cur, input logic [7:0] ofs,
                                       input int unsigned pb);
    logic [7:0] v;
    v = cur;
    if (ad_q == ofs) v = wb;
    else if (pin_acc) v[pidx] = wb[pb];
    return v;
  endfunction : upd_f

  logic [7:0] pin_word;
  assign pin_word = {s2_q[rpidx] & pad_d[rpidx].in_en, indis_q[rpidx], bidir_q[rpidx], slew_q[rpidx],
                     dm2_q[rpidx], dm1_q[rpidx], dm0_q[rpidx], latch_q[rpidx]};

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (ra == ppc_pkg::OFS_LATCH) rdata[7:0] = latch_q;
    else if (ra == ppc_pkg::OFS_STATE) rdata[7:0] = din_d;
    else if (ra == ppc_pkg::OFS_DM0) rdata[7:0] = dm0_q;
    else if (ra == ppc_pkg::OFS_DM1) rdata[7:0] = dm1_q;
    else if (ra == ppc_pkg::OFS_DM2) rdata[7:0] = dm2_q;
    else if (ra == ppc_pkg::OFS_SLEW) rdata[7:0] = slew_q;
    else if (ra == ppc_pkg::OFS_BIDIR) rdata[7:0] = bidir_q;
    else if (ra == ppc_pkg::OFS_INDIS) rdata[7:0] = indis_q;
    else if (ra == ppc_pkg::OFS_REGOUT) rdata[7:0] = regout_q;
    else if (ra == ppc_pkg::OFS_ITYP0) rdata[7:0] = ityp0_q;
    else if (ra == ppc_pkg::OFS_ITYP1) rdata[7:0] = ityp1_q;
    else if (ra == ppc_pkg::OFS_ISTAT) rdata[7:0] = istat_q;
    else if (ra == ppc_pkg::OFS_PCFG) rdata[7:0] = pcfg_q;
    else if (ra == ppc_pkg::OFS_OESEL) rdata = oesel_q;
    else if (rpin) rdata[7:0] = pin_word;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      aph_q <= 1'b0;
      wr_q  <= 1'b0;
      ad_q  <= 8'h00;
    end else begin
      aph_q <= take;
      wr_q  <= hwrite_i;
      ad_q  <= haddr_i[7:0];
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      latch_q  <= ppc_pkg::RST_BYTE;
      dm0_q    <= ppc_pkg::RST_BYTE;
      dm1_q    <= ppc_pkg::RST_BYTE;
      dm2_q    <= ppc_pkg::RST_BYTE;
      slew_q   <= ppc_pkg::RST_BYTE;
      bidir_q  <= ppc_pkg::RST_BYTE;
      indis_q  <= ppc_pkg::RST_BYTE;
      regout_q <= ppc_pkg::RST_BYTE;
      ityp0_q  <= ppc_pkg::RST_BYTE;
      ityp1_q  <= ppc_pkg::RST_BYTE;
      pcfg_q   <= ppc_pkg::RST_BYTE;
      oesel_q  <= 32'h0;
      boot_q   <= 1'b1;
    end else if (boot_q) begin
      // stored reset configuration loaded on the first edge after release
      dm0_q  <= nv_rstcfg_i.dm0;
      dm1_q  <= nv_rstcfg_i.dm1;
      dm2_q  <= nv_rstcfg_i.dm2;
      boot_q <= 1'b0;
    end else if (wr) begin
      latch_q  <= upd_f(latch_q, ppc_pkg::OFS_LATCH, ppc_pkg::PB_LATCH);
      dm0_q    <= upd_f(dm0_q, ppc_pkg::OFS_DM0, ppc_pkg::PB_DM);
      dm1_q    <= upd_f(dm1_q, ppc_pkg::OFS_DM1, ppc_pkg::PB_DM + 1);
      dm2_q    <= upd_f(dm2_q, ppc_pkg::OFS_DM2, ppc_pkg::PB_DM + 2);
      slew_q   <= upd_f(slew_q, ppc_pkg::OFS_SLEW, ppc_pkg::PB_SLEW);
      bidir_q  <= upd_f(bidir_q, ppc_pkg::OFS_BIDIR, ppc_pkg::PB_BIDIR);
      indis_q  <= upd_f(indis_q, ppc_pkg::OFS_INDIS, ppc_pkg::PB_INDIS);
      regout_q <= (ad_q == ppc_pkg::OFS_REGOUT) ? wb : regout_q;
      ityp0_q  <= (ad_q == ppc_pkg::OFS_ITYP0) ? wb : ityp0_q;
      ityp1_q  <= (ad_q == ppc_pkg::OFS_ITYP1) ? wb : ityp1_q;
      pcfg_q   <= (ad_q == ppc_pkg::OFS_PCFG) ? wb : pcfg_q;
      oesel_q  <= (ad_q == ppc_pkg::OFS_OESEL) ? hwdata_i : oesel_q;
    end
  end

  // ****************************************
  // port interrupt unit
  // ****************************************
  // new edges win over the read clear so no event is lost
  wire [7:0] istat_d = (rd_stat ? 8'h00 : istat_q) | edge_hit;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      istat_q <= 8'h00;
      irq_o   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_o   <= |istat_d;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pad_o       <= '0;
      din_o       <= 8'h00;
      lvttl_o     <= 1'b0;
      sp_thr_o    <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      pad_o       <= pad_d;
      din_o       <= din_d;
      lvttl_o     <= pcfg_q[ppc_pkg::PC_LVTTL];
      // two bits per special-pin pair, one shared reference each
      sp_thr_o    <= {pcfg_q[ppc_pkg::PC_THR +: 7], 1'b0};
      hrdata_o    <= (take && !hwrite_i) ? rdata : 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_irq_follows;
    @(posedge mclk_i) disable iff (!rst_n_i) (|edge_hit) |=> irq_o && ((istat_q & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("edge did not raise request");

  property p_no_rise_when_none;
    @(posedge mclk_i) disable iff (!rst_n_i) (!ityp0_q[0] && !ityp1_q[0]) |-> !edge_hit[0];
  endproperty
  a_no_rise_when_none: assert property (p_no_rise_when_none) else $error("edge on disabled pin");

  property p_irq_drop;
    @(posedge mclk_i) disable iff (!rst_n_i) (istat_q == 8'h00) |=> (irq_o == (|$past(edge_hit)));
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request without status");

  property p_analog_off;
    @(posedge mclk_i) disable iff (!rst_n_i) (!boot_q && !bidir_q[0] && {dm2_q[0], dm1_q[0], dm0_q[0]} == 3'h0)
      |=> !pad_o[0].in_en && !pad_o[0].drv_high && !pad_o[0].drv_low && !din_o[0];
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin not isolated");

  property p_bidir_input;
    @(posedge mclk_i) disable iff (!rst_n_i) (bidir_q[1] && !oe_pin[1]) |=> !pad_o[1].drv_high && !pad_o[1].drv_low;
  endproperty
  a_bidir_input: assert property (p_bidir_input) else $error("bidir pin drives with oe low");

  property p_indis;
    @(posedge mclk_i) disable iff (!rst_n_i) indis_q[2] |=> !pad_o[2].in_en;
  endproperty
  a_indis: assert property (p_indis) else $error("disabled buffer enabled");

  property p_strong;
    @(posedge mclk_i) disable iff (!rst_n_i) (!bidir_q[3] && {dm2_q[3], dm1_q[3], dm0_q[3]} == 3'h6)
      |=> (pad_o[3].drv_high == $past(latch_q[3])) && (pad_o[3].drv_low == !$past(latch_q[3]));
  endproperty
  a_strong: assert property (p_strong) else $error("strong drive wrong");

  property p_reg_nores;
    @(posedge mclk_i) disable iff (!rst_n_i) pad_o[4].reg_high |-> !pad_o[4].res_up && !pad_o[4].res_down;
  endproperty
  a_reg_nores: assert property (p_reg_nores) else $error("resistive with regulated");

  property p_slew_res;
    @(posedge mclk_i) disable iff (!rst_n_i) (pad_o[5].res_up || pad_o[5].res_down) |-> !pad_o[5].slew_slow;
  endproperty
  a_slew_res: assert property (p_slew_res) else $error("slew on resistive");

  c_irq: cover property (@(posedge mclk_i) disable iff (!rst_n_i) !irq_o ##1 irq_o);
  c_clear: cover property (@(posedge mclk_i) disable iff (!rst_n_i) rd_stat && (istat_q != 8'h00));
  c_pinwr: cover property (@(posedge mclk_i) disable iff (!rst_n_i) wr && pin_acc);

endmodule : ppc_port

/* ppc_pin_env.sv */
// external circuitry model on the eight port pins
// assumes pad controls from ppc_port and the bench clock
`timescale 1ns/1ps

module ppc_pin_env (
  input  wire logic                       mclk_i,
  input  wire ppc_pkg::ppc_pad_type [7:0] pad_i,
  input  wire logic [7:0]                 ext_en_i,
  input  wire logic [7:0]                 ext_val_i,
  output logic [7:0]                      pin_o
);
  logic [7:0] float_q = 8'h55;

  // ****************************************
  // pin level resolution
  // ****************************************
  // an undriven pin flips every cycle, so a stale level never passes
  always @(posedge mclk_i) begin
    float_q <= ~float_q;
  end

  // external drive beats a resistor, never a strong driver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_i[i].drv_high) pin_o[i] = 1'b1;
      else if (pad_i[i].drv_low) pin_o[i] = 1'b0;
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pad_i[i].res_up) pin_o[i] = 1'b1;
      else if (pad_i[i].res_down) pin_o[i] = 1'b0;
      else pin_o[i] = float_q[i];
    end
  end
endmodule : ppc_pin_env

/* test_port_pin_config_interrupts.sv */
// self-checking bench for the eight-pin port block
// assumes ppc_port, ppc_pin_env and one 200 MHz clock
`timescale 1ns/1ps

module test_port_pin_config_interrupts;
  logic                       mclk_i, rst_n_i, hsel_i, hwrite_i;
  logic [31:0]                haddr_i, hwdata_i, hrdata_o, rdv;
  logic [1:0]                 htrans_i;
  logic [2:0]                 hsize_i;
  logic                       hreadyout_o, hresp_o, lvttl_o, irq_o;
  logic [7:0]                 pin_in_i, sp_thr_o, din_o, ext_en, ext_val;
  logic [15:0]                aux_oe_i;
  ppc_pkg::ppc_rstcfg_type    nv_rstcfg_i;
  ppc_pkg::ppc_pad_type [7:0] pad_o;
  int                         n_fail, n_compared;

  ppc_port #(.NSPECIAL(4)) ppc_port_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .pin_in_i(pin_in_i), .aux_oe_i(aux_oe_i), .nv_rstcfg_i(nv_rstcfg_i),
    .pad_o(pad_o), .lvttl_o(lvttl_o), .sp_thr_o(sp_thr_o), .din_o(din_o), .irq_o(irq_o));
  ppc_pin_env ppc_pin_env_i (.mclk_i(mclk_i), .pad_i(pad_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_o(pin_in_i));

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // one single transfer; no wait count assumed, the watchdog cuts a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rdv = hrdata_o;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask : rchk

  // drive bits {high, low, up, down} of one pad
  task automatic pdrv(input int p, input logic [3:0] exp);
    check({28'h0, pad_o[p][6:3]}, {28'h0, exp});
  endtask : pdrv

  function automatic logic [3:0] drv_exp(input logic [2:0] m, input logic d);
    case (m)
      3'h2: drv_exp = d ? 4'h2 : 4'h4;
      3'h3: drv_exp = d ? 4'h8 : 4'h1;
      3'h4: drv_exp = d ? 4'h0 : 4'h4;
      3'h5: drv_exp = d ? 4'h8 : 4'h0;
      3'h6: drv_exp = d ? 4'h8 : 4'h4;
      3'h7: drv_exp = d ? 4'h2 : 4'h1;
      default: drv_exp = 4'h0;
    endcase
  endfunction : drv_exp

  task automatic complete_run;
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial begin
    #100us;
    n_fail++;
    complete_run;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n_i = 1'b0; hsel_i = 1'b1; haddr_i = 32'h0; htrans_i = 2'h0; hwrite_i = 1'b0;
    hsize_i = 3'h2; hwdata_i = 32'h0; aux_oe_i = 16'hfdff; ext_en = 8'h01; ext_val = 8'h00;
    nv_rstcfg_i = '{dm0: 8'h03, dm1: 8'h02, dm2: 8'h00};
    n_fail = 0; n_compared = 0;
    tick(10);
    check({25'h0, pad_o[1]}, 32'h0);
    rst_n_i <= 1'b1;
    tick(3);
    rchk(ppc_pkg::OFS_DM0, 32'h03);
    rchk(ppc_pkg::OFS_DM1, 32'h02);
    tick(2);
    pdrv(1, 4'h1);
    check({31'h0, pad_o[0].in_en}, 32'h1);
    check({31'h0, pad_o[2].in_en}, 32'h0);
    $display("test reset done");
    // every mode with both latch values, via the per-pin form
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(8'h44, {28'h0, m[2:0], d[0]});
        tick(4);
        pdrv(1, drv_exp(m[2:0], d[0]));
      end
    end
    wr(8'h44, 32'h0);
    $display("test modes done");
    wr(ppc_pkg::OFS_DM0, 32'h01);
    wr(ppc_pkg::OFS_DM1, 32'h08);
    wr(ppc_pkg::OFS_DM2, 32'h08);
    wr(ppc_pkg::OFS_LATCH, 32'h08);
    tick(6);
    pdrv(3, 4'h8);
    rchk(8'h4c, 32'h8d);
    $display("test forms done");
    // oe bit 9 low while every other aux line is high
    wr(8'h50, 32'h3d);
    wr(ppc_pkg::OFS_OESEL, 32'h0009_0000);
    tick(4);
    pdrv(4, 4'h0);
    check({31'h0, pad_o[4].in_en}, 32'h1);
    aux_oe_i <= 16'h0200;
    tick(4);
    pdrv(4, 4'h8);
    check({31'h0, pad_o[4].slew_slow}, 32'h1);
    $display("test bidir done");
    wr(8'h48, 32'h05);
    wr(8'h58, 32'h05);
    wr(ppc_pkg::OFS_REGOUT, 32'h44);
    wr(ppc_pkg::OFS_PCFG, 32'h07);
    tick(4);
    pdrv(2, 4'h0);
    check({31'h0, pad_o[2].reg_high}, 32'h1);
    pdrv(6, 4'h2);
    check({31'h0, pad_o[6].reg_high}, 32'h0);
    check({31'h0, lvttl_o}, 32'h1);
    check({24'h0, sp_thr_o}, 32'h06);
    $display("test special done");
    wr(ppc_pkg::OFS_ITYP0, 32'h01);
    tick(4);
    bus(1'b0, ppc_pkg::OFS_ISTAT, 32'h0);
    tick(2);
    ext_val <= 8'h01;
    tick(6);
    check({31'h0, irq_o}, 32'h1);
    rchk(ppc_pkg::OFS_ISTAT, 32'h01);
    tick(2);
    check({31'h0, irq_o}, 32'h0);
    rchk(ppc_pkg::OFS_ISTAT, 32'h0);
    ext_val <= 8'h00;
    tick(6);
    check({31'h0, irq_o}, 32'h0);
    wr(ppc_pkg::OFS_ITYP1, 32'h01);
    ext_val <= 8'h01;
    tick(6);
    bus(1'b0, ppc_pkg::OFS_ISTAT, 32'h0);
    tick(2);
    ext_val <= 8'h00;
    tick(6);
    rchk(ppc_pkg::OFS_ISTAT, 32'h01);
    $display("test irq done");
    ext_val <= 8'h01;
    tick(6);
    check({31'h0, din_o[0]}, 32'h1);
    bus(1'b0, ppc_pkg::OFS_STATE, 32'h0);
    check(rdv & 32'h1, 32'h1);
    wr(ppc_pkg::OFS_INDIS, 32'h01);
    tick(6);
    check({31'h0, pad_o[0].in_en}, 32'h0);
    check({31'h0, din_o[0]}, 32'h0);
    wr(8'h38, 32'hff);
    rchk(8'h38, 32'h0);
    $display("test input done");
    complete_run;
  end
endmodule : test_port_pin_config_interrupts
